// ===== pvsir_top.sv
// vendor status and interrupt register bank behind the serial management pins
`timescale 1ns/1ps
`default_nettype none
`include "pvsir_regs.svh"
module pvsir_top
    import pvsir_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h01,           // management address
    parameter int         PRE_LEN  = `PVSIR_PRE_LEN   // preamble ones needed
) (
    input  wire logic          clk_i,              // 40 MHz device clock
    input  wire logic          rst_i,              // synchronous reset
    input  wire logic          mdc_i,              // management clock pin
    input  wire logic          mdio_i,             // management data pin in
    output logic               mdio_o,             // management data out
    output logic               mdio_oe_o,          // drive enable for mdio
    input  wire pvsir_evt_type evt_i,              // event pulses
    input  wire logic          rx_sym_err_i,       // frame with symbol error
    input  wire logic          gig_link_ok_i,      // gigabit link good
    input  wire logic          fast_link_ok_i,     // 100 Mb/s link good
    output logic               remote_loopback_o,  // remote loopback on
    output logic               led_test_o,         // led test mode
    output logic               cable_diag_start_o, // cable test kick
    output logic               irq_o               // interrupt pin
);

    pvsir_state_type st;
    pvsir_state_type nxt;

    logic [1:0]  pin_s;
    logic [7:0]  flags;
    logic        mdc_rise;
    logic [12:0] full;
    logic        hdr_done;
    logic        addr_ok;
    logic        rd_go;
    logic        wr_go;
    logic        isr_clr;
    logic        cnt_clr;
    logic [4:0]  rd_adr;
    logic [4:0]  wr_adr;
    logic [15:0] wr_dat;
    logic [15:0] rdata;
    logic        any_irq;

    if (PRE_LEN < 1 || PRE_LEN > 63)
    begin : g_bad_pre
        $error("pvsir_top: PRE_LEN must lie in 1..63");
    end

    pvsir_sync #(
        .W (2)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({mdc_i, mdio_i}),
        .q_o   (pin_s)
    );

    pvsir_evt #(
        .W (`PVSIR_EVT_N)
    ) u_evt (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .set_i   (evt_i),
        .clr_i   (isr_clr),
        .flags_o (flags)
    );

    always_comb
    begin
        nxt        = st;
        nxt.mdc_q  = pin_s[1];
        nxt.cab_go = 1'b0;

        mdc_rise = pin_s[1] & ~st.mdc_q;
        full     = {st.hdr[11:0], pin_s[0]};
        rd_adr   = full[4:0];
        hdr_done = mdc_rise && st.phase == PVSIR_HDR && st.bit_cnt == `PVSIR_HDR_BITS - 5'h01;
        addr_ok  = full[12] && full[9:5] == PHY_ADDR;
        rd_go    = hdr_done && addr_ok && full[11:10] == `PVSIR_OP_RD;
        wr_adr   = st.hdr[4:0];
        wr_dat   = {st.sh[14:0], pin_s[0]};
        wr_go    = mdc_rise && st.phase == PVSIR_DATA && st.hit && !st.is_rd
                   && st.bit_cnt == `PVSIR_DATA_BITS - 5'h01;
        isr_clr  = rd_go && rd_adr == `PVSIR_A_INTCS;
        cnt_clr  = rd_go && rd_adr == `PVSIR_A_RXCNT;

        // read data is taken when the address arrives, so clears act on what was shown
        rdata = 16'h0000;
        case (rd_adr)
            `PVSIR_A_LPLED:  rdata = st.lpled;
            `PVSIR_A_CABLE:  rdata = {st.cab_go, st.cab, 8'h00};
            `PVSIR_A_LSTAT:
            begin
                rdata[`PVSIR_B_GIG]  = gig_link_ok_i;
                rdata[`PVSIR_B_FAST] = fast_link_ok_i;
            end
            `PVSIR_A_RXCNT:  rdata = st.rxcnt;
            `PVSIR_A_INTCS:  rdata = {st.int_en, flags};
            `PVSIR_A_PHYCTL: rdata[`PVSIR_B_POL] = st.int_pol;
            default:         rdata = 16'h0000;
        endcase

        if (mdc_rise)
        begin
            case (st.phase)
                PVSIR_PRE:
                begin
                    if (pin_s[0])
                    begin
                        if (st.pre_cnt != `PVSIR_PRE_MAX)
                            nxt.pre_cnt = st.pre_cnt + 6'h01;
                    end
                    else
                    begin
                        // this zero is the first start bit
                        if (st.pre_cnt >= 6'(PRE_LEN))
                        begin
                            nxt.phase   = PVSIR_HDR;
                            nxt.bit_cnt = 5'h00;
                        end
                        nxt.pre_cnt = 6'h00;
                    end
                end
                PVSIR_HDR:
                begin
                    nxt.hdr     = full;
                    nxt.bit_cnt = st.bit_cnt + 5'h01;
                    if (hdr_done)
                    begin
                        // foreign frames are still walked to their end so their
                        // trailing ones never pass for a fresh preamble
                        nxt.phase   = PVSIR_TA;
                        nxt.bit_cnt = 5'h00;
                        nxt.is_rd   = full[11:10] == `PVSIR_OP_RD;
                        nxt.hit     = addr_ok && (full[11:10] == `PVSIR_OP_RD
                                      || full[11:10] == `PVSIR_OP_WR);
                        if (rd_go)
                            nxt.sh = rdata;
                    end
                end
                PVSIR_TA:
                begin
                    nxt.bit_cnt = st.bit_cnt + 5'h01;
                    if (st.bit_cnt == 5'h00)
                    begin
                        if (st.hit && st.is_rd)
                        begin
                            nxt.mdio_oe = 1'b1;
                            nxt.mdio_o  = 1'b0;
                        end
                    end
                    else
                    begin
                        nxt.phase   = PVSIR_DATA;
                        nxt.bit_cnt = 5'h00;
                        if (st.hit && st.is_rd)
                        begin
                            nxt.mdio_o = st.sh[15];
                            nxt.sh     = {st.sh[14:0], 1'b0};
                        end
                    end
                end
                PVSIR_DATA:
                begin
                    nxt.bit_cnt = st.bit_cnt + 5'h01;
                    if (st.hit && st.is_rd)
                    begin
                        nxt.mdio_o = st.sh[15];
                        nxt.sh     = {st.sh[14:0], 1'b0};
                    end
                    else
                        nxt.sh = wr_dat;
                    if (st.bit_cnt == `PVSIR_DATA_BITS - 5'h01)
                    begin
                        nxt.phase   = PVSIR_PRE;
                        nxt.pre_cnt = 6'h00;
                        nxt.mdio_oe = 1'b0;
                        nxt.mdio_o  = 1'b0;
                    end
                end
                default:
                begin
                    nxt.phase   = PVSIR_PRE;
                    nxt.pre_cnt = 6'h00;
                end
            endcase
        end

        if (wr_go)
        begin
            case (wr_adr)
                `PVSIR_A_LPLED:  nxt.lpled = wr_dat & `PVSIR_LPLED_WMASK;
                `PVSIR_A_CABLE:
                begin
                    nxt.cab    = wr_dat[14:8];
                    nxt.cab_go = wr_dat[`PVSIR_B_CABGO];
                end
                `PVSIR_A_INTCS:  nxt.int_en = wr_dat[15:8];
                `PVSIR_A_PHYCTL: nxt.int_pol = wr_dat[`PVSIR_B_POL];
                default:         nxt.int_pol = st.int_pol;
            endcase
        end

        // saturating rather than wrapping keeps a flood of errors from reading as a few
        // count, clear on read; a count in the read cycle survives
        if (cnt_clr)
            nxt.rxcnt = {15'h0000, rx_sym_err_i};
        else if (rx_sym_err_i && st.rxcnt != `PVSIR_CNT_MAX)
            nxt.rxcnt = st.rxcnt + 16'h0001;

        any_irq = |(flags & st.int_en);
        // taken from a flop so a flag clear and an enable write in one cycle cannot glitch the pin
        // polarity applied
        nxt.irq = any_irq ~^ st.int_pol;

        if (rst_i)
        begin
            nxt       = '0;
            nxt.phase = PVSIR_PRE;
            nxt.lpled = `PVSIR_LPLED_RST;
            nxt.irq   = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
        st <= nxt;

    assign mdio_o             = st.mdio_o;
    assign mdio_oe_o          = st.mdio_oe;
    assign remote_loopback_o  = st.lpled[`PVSIR_B_RLB];
    assign led_test_o         = st.lpled[`PVSIR_B_LEDT];
    assign cable_diag_start_o = st.cab_go;
    assign irq_o              = st.irq;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_wr_lpled;
        wr_go && wr_adr == `PVSIR_A_LPLED;
    endsequence

    sequence s_rd_isr;
        rd_go && rd_adr == `PVSIR_A_INTCS;
    endsequence

    sequence s_rd_stat;
        rd_go && rd_adr == `PVSIR_A_LSTAT;
    endsequence

    AST_RLB_WR: assert property (s_wr_lpled |=> remote_loopback_o == $past(wr_dat[8]))
        else $error("remote loopback missed its write");

    AST_LED_WR: assert property (s_wr_lpled |=> led_test_o == $past(wr_dat[3]))
        else $error("led test missed its write");

    AST_GIG_RD: assert property (s_rd_stat |=> st.sh[`PVSIR_B_GIG] == $past(gig_link_ok_i))
        else $error("gigabit status not shown");

    AST_FAST_RD: assert property (s_rd_stat |=> st.sh[`PVSIR_B_FAST] == $past(fast_link_ok_i))
        else $error("fast status not shown");

    AST_CNT_CLR: assert property (cnt_clr |=> st.rxcnt == {15'h0000, $past(rx_sym_err_i)})
        else $error("counter not cleared by read");

    AST_CNT_INC: assert property ((!cnt_clr && rx_sym_err_i && st.rxcnt != `PVSIR_CNT_MAX)
        |=> st.rxcnt == $past(st.rxcnt) + 16'h0001)
        else $error("counter did not advance");

    AST_EN_WR: assert property ((wr_go && wr_adr == `PVSIR_A_INTCS)
        |=> st.int_en == $past(wr_dat[15:8]))
        else $error("enables missed their write");

    AST_JAB_LATCH: assert property (evt_i.jabber |-> ##1 flags[7] ##1 flags[7] || $past(isr_clr))
        else $error("jabber not latched");

    AST_RXE_LATCH: assert property (evt_i.rx_err |=> flags[6])
        else $error("receive error not latched");

    AST_ISR_CLR: assert property (s_rd_isr ##0 !(|evt_i) |=> flags == 8'h00)
        else $error("status flags survived a read");

    AST_IRQ_HIGH: assert property (((|(evt_i & st.int_en)) && st.int_pol)
        |-> ##2 irq_o)
        else $error("enabled event did not raise interrupt");

    AST_IRQ_LOW: assert property (((|(evt_i & st.int_en)) && !st.int_pol)
        |-> ##2 !irq_o)
        else $error("enabled event did not pull active-low pin down");

    AST_IRQ_IDLE: assert property ((!st.int_pol && !(|(flags & st.int_en))) |=> irq_o)
        else $error("active-low pin not idle high");

    AST_POL_WR: assert property ((wr_go && wr_adr == `PVSIR_A_PHYCTL)
        |=> st.int_pol == $past(wr_dat[`PVSIR_B_POL]))
        else $error("polarity missed its write");

    AST_LPLED_HOLD: assert property (!(wr_go && wr_adr == `PVSIR_A_LPLED) |=> $stable(st.lpled))
        else $error("loopback register changed without a write");

    AST_EN_HOLD: assert property (!(wr_go && wr_adr == `PVSIR_A_INTCS) |=> $stable(st.int_en))
        else $error("enables changed without a write");

    AST_CNT_HOLD: assert property ((!cnt_clr && !rx_sym_err_i) |=> $stable(st.rxcnt))
        else $error("counter moved without an error or a read");

endmodule // pvsir_top
`default_nettype wire

// ===== pvsir_regs.svh
// register offsets, field positions, reset values and frame counts of the vendor register bank
`ifndef PVSIR_REGS_SVH
`define PVSIR_REGS_SVH
`define PVSIR_A_LPLED      5'h11
`define PVSIR_A_CABLE      5'h12
`define PVSIR_A_LSTAT      5'h13
`define PVSIR_A_RXCNT      5'h15
`define PVSIR_A_INTCS      5'h1b
`define PVSIR_A_PHYCTL     5'h1f
`define PVSIR_B_RLB        8
`define PVSIR_B_LEDT       3
`define PVSIR_B_GIG        2
`define PVSIR_B_FAST       1
`define PVSIR_B_POL        14
`define PVSIR_B_CABGO      15
`define PVSIR_LPLED_RST    16'h02f0
`define PVSIR_LPLED_WMASK  16'hfffe
`define PVSIR_OP_RD        2'h2
`define PVSIR_OP_WR        2'h1
`define PVSIR_PRE_LEN      32
`define PVSIR_PRE_MAX      6'h3f
`define PVSIR_HDR_BITS     5'h0d
`define PVSIR_DATA_BITS    5'h10
`define PVSIR_CNT_MAX      16'hffff
`define PVSIR_EVT_N        8
`endif

// ===== pvsir_pkg.sv
// types shared by the vendor register bank modules
`default_nettype none
package pvsir_pkg;

    typedef enum logic [1:0] {PVSIR_PRE, PVSIR_HDR, PVSIR_TA, PVSIR_DATA} pvsir_phase_type;

    // bit 7 down to bit 0 of the interrupt status byte
    typedef struct packed {
        logic jabber;
        logic rx_err;
        logic page_rx;
        logic pd_fault;
        logic lp_ack;
        logic link_down;
        logic remote_fault;
        logic link_up;
    } pvsir_evt_type;

    typedef struct packed {
        pvsir_phase_type phase;
        logic [5:0]      pre_cnt;
        logic [4:0]      bit_cnt;
        logic [12:0]     hdr;
        logic            is_rd;
        logic            hit;
        logic [15:0]     sh;
        logic            mdc_q;
        logic            mdio_o;
        logic            mdio_oe;
        logic [15:0]     lpled;
        logic [6:0]      cab;
        logic            cab_go;
        logic [15:0]     rxcnt;
        logic [7:0]      int_en;
        logic            int_pol;
        logic            irq;
    } pvsir_state_type;

endpackage
`default_nettype wire

// ===== pvsir_sync.sv
// three-flop pin synchroniser; a change is taken once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pvsir_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,   // device clock
    input  wire logic         rst_i,   // synchronous reset
    input  wire logic [W-1:0] d_i,     // asynchronous pins
    output logic      [W-1:0] q_o      // filtered levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } pvsir_sync_state_type;

    pvsir_sync_state_type st;
    pvsir_sync_state_type nxt;
    logic [W-1:0]         agree;

    if (W < 1)
    begin : g_bad_w
        $error("pvsir_sync: W must be at least 1");
    end

    always_comb
    begin
        nxt     = st;
        agree   = ~(st.s2 ^ st.s3);
        nxt.s1  = d_i;
        nxt.s2  = st.s1;
        nxt.s3  = st.s2;
        nxt.lvl = (agree & st.s3) | (~agree & st.lvl);
        if (rst_i)
            nxt = '0;
    end

    always_ff @(posedge clk_i)
        st <= nxt;

    assign q_o = st.lvl;

    AST_SYNC_AGREE: assert property (@(posedge clk_i) disable iff (rst_i)
        ((st.lvl ^ $past(st.lvl)) & $past(st.s2 ^ st.s3)) == '0)
        else $error("level changed without agreeing stages");

endmodule // pvsir_sync
`default_nettype wire

// ===== pvsir_evt.sv
// sticky event flags; a new event beats a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module pvsir_evt #(
    parameter int W = 8
) (
    input  wire logic         clk_i,   // device clock
    input  wire logic         rst_i,   // synchronous reset
    input  wire logic [W-1:0] set_i,   // one-cycle event pulses
    input  wire logic         clr_i,   // clear-on-read strobe
    output logic      [W-1:0] flags_o  // latched flags
);
    typedef struct packed {
        logic [W-1:0] flags;
    } pvsir_evt_state_type;

    pvsir_evt_state_type st;
    pvsir_evt_state_type nxt;

    if (W < 1)
    begin : g_bad_w
        $error("pvsir_evt: W must be at least 1");
    end

    always_comb
    begin
        nxt = st;
        nxt.flags = set_i | (st.flags & ~{W{clr_i}});
        if (rst_i)
            nxt = '0;
    end

    always_ff @(posedge clk_i)
        st <= nxt;

    assign flags_o = st.flags;

    AST_SET_WINS: assert property (@(posedge clk_i) disable iff (rst_i)
        (|set_i) |=> ((flags_o & $past(set_i)) == $past(set_i)))
        else $error("event lost against clear");

    AST_CLR_ALL: assert property (@(posedge clk_i) disable iff (rst_i)
        (clr_i && !(|set_i)) |=> (flags_o == '0))
        else $error("flags survived a read");

endmodule // pvsir_evt
`default_nettype wire

// ===== pvsir_mdio_master.sv
// station management controller model that sends serial management frames
`timescale 1ns/1ps
`default_nettype none
`include "pvsir_regs.svh"
module pvsir_mdio_master #(
    parameter int PRE_LEN = 4,    // preamble ones sent
    parameter int HALF    = 10    // mdc half period in device clocks
) (
    input  wire logic clk_i,      // device clock
    input  wire logic mdio_i,     // resolved wire level
    output logic      mdc_o,      // management clock, still between frames
    output logic      mdio_o,     // data driven by the controller
    output logic      mdio_oe_o   // controller drives the wire
);
    initial
    begin
        mdc_o = 1'b0;
        mdio_o = 1'b1;
        mdio_oe_o = 1'b0;
    end

    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] w;
        int          i;
        w = {2'b01, op, phy, ra, 2'b10, wd};
        rd = 16'h0000;
        for (i = -PRE_LEN; i < 32; i++)
        begin
            @(posedge clk_i);
            // a read hands the wire to the device from the turnaround on
            mdio_oe_o <= !(op == `PVSIR_OP_RD && i >= 14);
            mdio_o <= (i < 0) ? 1'b1 : w[31-i];
            repeat (HALF) @(posedge clk_i);
            // the device changes its bit well after this edge, so sampling here is safe
            if (i >= 16)
                rd = {rd[14:0], mdio_i};
            mdc_o <= 1'b1;
            repeat (HALF) @(posedge clk_i);
            mdc_o <= 1'b0;
        end
        @(posedge clk_i);
        mdio_oe_o <= 1'b0;
    endtask
endmodule // pvsir_mdio_master
`default_nettype wire

// ===== pvsir_top_tb_top.sv
// self-checking testbench of the vendor status and interrupt register bank
`timescale 1ns/1ps
`default_nettype none
`include "pvsir_regs.svh"
module pvsir_top_tb_top;
    import pvsir_pkg::*;
    localparam int         PRE = 4;
    localparam logic [4:0] PHY = 5'h01;
    logic          clk_i = 1'b0;
    logic          rst = 1'b1;
    pvsir_evt_type evt = '0;
    logic          rx_err = 1'b0;
    logic          gig = 1'b0;
    logic          fast = 1'b0;
    logic          mdc, m_o, m_oe, dut_o, dut_oe, rlb, ledt, cab, irq, mdio_w;
    logic          cab_seen = 1'b0;
    int            fails = 0;
    int            num_checks = 0;
    int            cyc = 0;
    logic [15:0]   d, rdv;
    int            i, n;

    always #12.5 clk_i = ~clk_i;
    // pull-up wins when nobody drives
    assign mdio_w = (dut_oe ? dut_o : 1'b1) & (m_oe ? m_o : 1'b1);

    pvsir_top #(.PHY_ADDR(PHY), .PRE_LEN(PRE)) i_pvsir_top (
        .clk_i(clk_i), .rst_i(rst), .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(dut_o),
        .mdio_oe_o(dut_oe), .evt_i(evt), .rx_sym_err_i(rx_err), .gig_link_ok_i(gig),
        .fast_link_ok_i(fast), .remote_loopback_o(rlb), .led_test_o(ledt),
        .cable_diag_start_o(cab), .irq_o(irq));
    pvsir_mdio_master #(.PRE_LEN(PRE), .HALF(10)) i_pvsir_mdio_master (
        .clk_i(clk_i), .mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(m_o), .mdio_oe_o(m_oe));

    always @(posedge clk_i)
    begin
        if (cab === 1'b1)
            cab_seen <= 1'b1;
        cyc++;
        if (cyc == 80000)
        begin
            fails++;
            $display("timeout after %0d cycles", cyc);
            results();
        end
    end

    function automatic logic [15:0] exp_lpled(input logic [15:0] v);
        return v & `PVSIR_LPLED_WMASK;
    endfunction
    function automatic logic [15:0] exp_lstat(input logic g, input logic f);
        return {13'h0000, g, f, 1'b0};
    endfunction

    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] v);
        logic [15:0] unused;
        i_pvsir_mdio_master.frame(`PVSIR_OP_WR, PHY, ra, v, unused);
    endtask
    task automatic rdchk(input string what, input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] got;
        i_pvsir_mdio_master.frame(`PVSIR_OP_RD, PHY, ra, 16'h0000, got);
        chk16(what, exp, got);
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask
    task automatic pulse(input pvsir_evt_type e);
        @(posedge clk_i);
        evt <= e;
        @(posedge clk_i);
        evt <= '0;
        tick(3);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        n = $urandom(83);
        tick(5);
        rst <= 1'b0;
        tick(5);
        chk1("irq_o", 1'b1, irq);
        chk1("remote_loopback_o", 1'b0, rlb);
        chk1("led_test_o", 1'b0, ledt);
        rdchk("lpled", `PVSIR_A_LPLED, `PVSIR_LPLED_RST);
        rdchk("lstat", `PVSIR_A_LSTAT, 16'h0000);
        rdchk("rxcnt", `PVSIR_A_RXCNT, 16'h0000);
        rdchk("intcs", `PVSIR_A_INTCS, 16'h0000);
        rdchk("phyctl", `PVSIR_A_PHYCTL, 16'h0000);
        rdchk("unmapped", 5'h10, 16'h0000);
        $display("test reset done");

        for (i = 0; i < 6; i++)
        begin
            d = (i == 0) ? 16'h0108 : (i == 1) ? 16'hffff : (i == 2) ? 16'h0000 : 16'($urandom);
            wr(`PVSIR_A_LPLED, d);
            tick(2);
            chk1("remote_loopback_o", d[8], rlb);
            chk1("led_test_o", d[3], ledt);
            rdchk("lpled", `PVSIR_A_LPLED, exp_lpled(d));
        end
        // a frame for another station must leave the bank untouched
        i_pvsir_mdio_master.frame(`PVSIR_OP_WR, PHY ^ 5'h01, `PVSIR_A_LPLED, ~d, rdv);
        rdchk("lpled", `PVSIR_A_LPLED, exp_lpled(d));
        $display("test loopback_led done");

        for (i = 0; i < 4; i++)
        begin
            @(posedge clk_i);
            gig <= i[1];
            fast <= i[0];
            wr(`PVSIR_A_LSTAT, 16'hffff);
            rdchk("lstat", `PVSIR_A_LSTAT, exp_lstat(i[1], i[0]));
        end
        $display("test link done");

        n = $urandom_range(40, 1);
        for (i = 0; i < n; i++)
        begin
            @(posedge clk_i);
            rx_err <= 1'b1;
        end
        @(posedge clk_i);
        rx_err <= 1'b0;
        rdchk("rxcnt", `PVSIR_A_RXCNT, 16'(n));
        rdchk("rxcnt", `PVSIR_A_RXCNT, 16'h0000);
        $display("test counter done");

        for (i = 0; i < 8; i++)
        begin
            d = 16'h0100 << i;
            wr(`PVSIR_A_INTCS, d);
            pulse(pvsir_evt_type'(8'h01 << i));
            chk1("irq_o", 1'b0, irq);
            rdchk("intcs", `PVSIR_A_INTCS, d | (16'h0001 << i));
            tick(2);
            chk1("irq_o", 1'b1, irq);
            rdchk("intcs", `PVSIR_A_INTCS, d);
        end
        wr(`PVSIR_A_INTCS, 16'h00ff);
        n = $urandom_range(255, 1);
        pulse(pvsir_evt_type'(n[7:0]));
        chk1("irq_o", 1'b1, irq);
        rdchk("intcs", `PVSIR_A_INTCS, 16'(n));
        $display("test interrupt done");

        wr(`PVSIR_A_PHYCTL, 16'hffff);
        tick(2);
        chk1("irq_o", 1'b0, irq);
        rdchk("phyctl", `PVSIR_A_PHYCTL, 16'h4000);
        wr(`PVSIR_A_INTCS, 16'h8000);
        pulse(pvsir_evt_type'(8'h80));
        chk1("irq_o", 1'b1, irq);
        rdchk("intcs", `PVSIR_A_INTCS, 16'h8080);
        $display("test polarity done");

        // a reset in mid-run must bring back the documented defaults
        @(posedge clk_i);
        rst <= 1'b1;
        tick(5);
        rst <= 1'b0;
        tick(5);
        chk1("irq_o", 1'b1, irq);
        chk1("remote_loopback_o", 1'b0, rlb);
        chk1("led_test_o", 1'b0, ledt);
        rdchk("phyctl", `PVSIR_A_PHYCTL, 16'h0000);
        rdchk("lpled", `PVSIR_A_LPLED, `PVSIR_LPLED_RST);
        $display("test second reset done");

        wr(`PVSIR_A_CABLE, 16'hff00);
        chk1("cable_diag_start_o", 1'b1, cab_seen);
        rdchk("cable", `PVSIR_A_CABLE, 16'h7f00);
        $display("test cable done");
        results();
    end
endmodule // pvsir_top_tb_top
`default_nettype wire
